/* core/e1pc_pkg.sv */
package e1pc_pkg;
  // Clock and interval timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int LONG_MS       = 1000;                         // Long interval, 1 s
  localparam int SHORT_US      = 62_500;                       // Short interval, 62.5 ms
  localparam int LONG_CYCLES   = (CLK_HZ / 1000) * LONG_MS;
  localparam int SHORT_CYCLES  = (CLK_HZ / 1_000_000) * SHORT_US;
  localparam int TIMER_W       = 26;

  // Counter widths
  localparam int VIOL_W        = 16;
  localparam int CRC_W         = 10;
  localparam int FAR_END_BLOCK_ERROR_W        = 10;
  localparam int FAS_W         = 12;
  localparam logic [15:0] VIOL_MAX = 16'hFFFF;

  // Read port
  localparam int ADDR_W        = 8;
  localparam int DATA_W        = 8;
  localparam logic [7:0] ADDR_VIOL_HIGH      = 8'h00;
  localparam logic [7:0] ADDR_VIOL_LOW       = 8'h01;
  localparam logic [7:0] ADDR_CRC_FAS_HIGH   = 8'h02;
  localparam logic [7:0] ADDR_CRC_LOW        = 8'h03;
  localparam logic [7:0] ADDR_FAR_END_BLOCK_ERROR_FAS_LOW   = 8'h04;
  localparam logic [7:0] ADDR_FAR_END_BLOCK_ERROR_LOW       = 8'h05;
  localparam logic [7:0] READ_UNMAPPED       = 8'h00;

  // Field positions in the shared bytes
  localparam int FAS_HIGH_LSB  = 6;   // Count bits 11..6 go to byte bits 7..2
  localparam int SPLIT_LSB     = 8;   // Bits 9..8 of 10-bit counts go to byte bits 1..0
endpackage

/* core/e1pc_interval_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module e1pc_interval_timer #(
  parameter int LONG_CYCLES  = e1pc_pkg::LONG_CYCLES,
  parameter int SHORT_CYCLES = e1pc_pkg::SHORT_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic intervalSelect,
  output var  logic tick
);
  typedef struct packed {
    logic [e1pc_pkg::TIMER_W-1:0] cnt;
    logic                         tick;
  } e1pc_timer_st_t;

  e1pc_timer_st_t st_reg;
  e1pc_timer_st_t st_next;
  logic [e1pc_pkg::TIMER_W-1:0] lastCount;

  // Limits must fit the counter and give at least two cycles per interval
  if (LONG_CYCLES < 2 || SHORT_CYCLES < 2 || LONG_CYCLES >= (1 << e1pc_pkg::TIMER_W) ||
      SHORT_CYCLES >= (1 << e1pc_pkg::TIMER_W)) begin : g_bad_limits
    $error("interval timer limits out of range");
  end

  // Terminal count follows the select; a switch to the short interval ends a long run already past the short count at once
  always_comb begin
    lastCount = intervalSelect ? e1pc_pkg::TIMER_W'(SHORT_CYCLES - 1)
                               : e1pc_pkg::TIMER_W'(LONG_CYCLES - 1);
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt >= lastCount) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + e1pc_pkg::TIMER_W'(1);
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_tick;
    tick;
  endsequence
  sequence s_quiet;
    !tick [*8];
  endsequence

  a_tick_spacing: assert property (s_tick |=> s_quiet)
    else $error("interval ticks too close");
  // Tick fires one cycle after the count reaches the terminal count
  a_tick_at_term: assert property ((st_reg.cnt >= lastCount) |=> tick)
    else $error("tick missing at terminal count");
endmodule
`default_nettype wire

/* core/e1pc_error_counters.sv */
`timescale 1ns/1ps
`default_nettype none
module e1pc_error_counters #(
  parameter int LONG_CYCLES  = e1pc_pkg::LONG_CYCLES,
  parameter int SHORT_CYCLES = e1pc_pkg::SHORT_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        intervalSelect,
  input  wire logic                        violationTypeSelect,
  input  wire logic                        receiveLineCodeSelect,
  input  wire logic                        rxBitValid,
  input  wire logic                        rxPosMark,
  input  wire logic                        rxNegMark,
  input  wire logic                        crcErrorPulse,
  input  wire logic                        eBitStrobe,
  input  wire logic                        eBitValue,
  input  wire logic                        fasErrorPulse,
  input  wire logic                        receiveSyncLossStatus,
  input  wire logic                        crcMultiframeSyncLoss,
  input  wire logic [e1pc_pkg::ADDR_W-1:0] rdAddr,
  output var  logic [e1pc_pkg::DATA_W-1:0] rdData,
  output var  logic                        oneSecondTimerFlag
);
  typedef struct packed {
    logic [e1pc_pkg::VIOL_W-1:0] violRun;
    logic [e1pc_pkg::VIOL_W-1:0] violHeld;
    logic [e1pc_pkg::CRC_W-1:0]  crcRun;
    logic [e1pc_pkg::CRC_W-1:0]  crcHeld;
    logic [e1pc_pkg::FAR_END_BLOCK_ERROR_W-1:0] febeRun;
    logic [e1pc_pkg::FAR_END_BLOCK_ERROR_W-1:0] febeHeld;
    logic [e1pc_pkg::FAS_W-1:0]  fasRun;
    logic [e1pc_pkg::FAS_W-1:0]  fasHeld;
    logic                        haveMark;
    logic                        lastMarkPos;
    logic                        haveBpv;
    logic                        lastBpvPos;
    logic [1:0]                  zeroRun;
    logic [e1pc_pkg::DATA_W-1:0] rdData;
    logic                        secFlag;
  } e1pc_state_t;

  e1pc_state_t st_reg;
  e1pc_state_t st_next;

  logic tick;
  logic mark;
  logic bpv;
  logic hdb3Codeword;
  logic codeViol;
  logic violInc;
  logic crcInc;
  logic febeInc;
  logic fasInc;
  logic framingLost;

  // Short interval must not outlast the long one, and both need two cycles
  if (SHORT_CYCLES < 2 || LONG_CYCLES < SHORT_CYCLES) begin : g_bad_intervals
    $error("error counter interval limits out of range");
  end

  // Interval boundary source
  e1pc_interval_timer #(
    .LONG_CYCLES  (LONG_CYCLES),
    .SHORT_CYCLES (SHORT_CYCLES)
  ) u_timer (
    .clock          (clock),
    .rst            (rst),
    .intervalSelect (intervalSelect),
    .tick           (tick)
  );

  // Line symbol classification; a symbol with both marks is treated as positive
  always_comb begin
    mark = rxBitValid && (rxPosMark || rxNegMark);
    bpv = mark && st_reg.haveMark && (rxPosMark == st_reg.lastMarkPos);
    // 000V and B00V both show two zeros before V
    hdb3Codeword = bpv && receiveLineCodeSelect && (st_reg.zeroRun >= 2'd2);
    // Two violations in a row with the same polarity
    codeViol = bpv && st_reg.haveBpv && (rxPosMark == st_reg.lastBpvPos);
    // No sync term gates the violation count
    violInc = violationTypeSelect ? codeViol : (bpv && !hdb3Codeword);
  end

  // Event qualification for the framed counters
  always_comb begin
    // Frame or CRC multiframe loss gates CRC and far-end counting
    framingLost = receiveSyncLossStatus || crcMultiframeSyncLoss;
    crcInc = crcErrorPulse && !framingLost;
    // The framer strobes the E bits of frames 13 and 15
    febeInc = eBitStrobe && !eBitValue && !framingLost;
    // Alignment errors ignored while sync is lost
    fasInc = fasErrorPulse && !receiveSyncLossStatus;
  end

  // Next-state logic: counting, latching and read path
  always_comb begin
    st_next = st_reg;
    st_next.secFlag = tick;

    // Line history for violation classification
    if (mark) begin
      st_next.haveMark    = 1'b1;
      st_next.lastMarkPos = rxPosMark;
      st_next.zeroRun     = 2'd0;
    end else if (rxBitValid && st_reg.zeroRun != 2'd3) begin
      st_next.zeroRun = st_reg.zeroRun + 2'd1;
    end
    if (bpv) begin
      st_next.haveBpv    = 1'b1;
      st_next.lastBpvPos = rxPosMark;
    end

    if (tick) begin
      // Copy including this cycle's event, restart from it
      // All four counts refresh on the same boundary
      st_next.violHeld = (violInc && st_reg.violRun != e1pc_pkg::VIOL_MAX)
                         ? st_reg.violRun + e1pc_pkg::VIOL_W'(1) : st_reg.violRun;
      st_next.crcHeld  = st_reg.crcRun + e1pc_pkg::CRC_W'(crcInc);
      st_next.febeHeld = st_reg.febeRun + e1pc_pkg::FAR_END_BLOCK_ERROR_W'(febeInc);
      st_next.fasHeld  = st_reg.fasRun + e1pc_pkg::FAS_W'(fasInc);
      st_next.violRun  = e1pc_pkg::VIOL_W'(violInc);
      st_next.crcRun   = e1pc_pkg::CRC_W'(crcInc);
      st_next.febeRun  = e1pc_pkg::FAR_END_BLOCK_ERROR_W'(febeInc);
      st_next.fasRun   = e1pc_pkg::FAS_W'(fasInc);
    end else begin
      // Hold at full scale, never wrap
      if (violInc && st_reg.violRun != e1pc_pkg::VIOL_MAX) begin
        st_next.violRun = st_reg.violRun + e1pc_pkg::VIOL_W'(1);
      end
      // Short counts cannot fill within one second, so they simply count
      st_next.crcRun  = st_reg.crcRun + e1pc_pkg::CRC_W'(crcInc);
      st_next.febeRun = st_reg.febeRun + e1pc_pkg::FAR_END_BLOCK_ERROR_W'(febeInc);
      st_next.fasRun  = st_reg.fasRun + e1pc_pkg::FAS_W'(fasInc);
    end

    // Read path, one cycle behind the address; host must fetch before the next boundary
    case (rdAddr)
      // Violation count high and low bytes
      e1pc_pkg::ADDR_VIOL_HIGH:    st_next.rdData = st_reg.violHeld[15:8];
      e1pc_pkg::ADDR_VIOL_LOW:     st_next.rdData = st_reg.violHeld[7:0];
      // Alignment high bits over CRC top bits
      e1pc_pkg::ADDR_CRC_FAS_HIGH: st_next.rdData = {st_reg.fasHeld[11:e1pc_pkg::FAS_HIGH_LSB],
                                                     st_reg.crcHeld[9:e1pc_pkg::SPLIT_LSB]};
      e1pc_pkg::ADDR_CRC_LOW:      st_next.rdData = st_reg.crcHeld[7:0];
      // Alignment low bits over far-end top bits
      e1pc_pkg::ADDR_FAR_END_BLOCK_ERROR_FAS_LOW: st_next.rdData = {st_reg.fasHeld[e1pc_pkg::FAS_HIGH_LSB-1:0],
                                                     st_reg.febeHeld[9:e1pc_pkg::SPLIT_LSB]};
      e1pc_pkg::ADDR_FAR_END_BLOCK_ERROR_LOW:     st_next.rdData = st_reg.febeHeld[7:0];
      default:                     st_next.rdData = e1pc_pkg::READ_UNMAPPED;
    endcase
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Flag pulses for one cycle per interval
  assign oneSecondTimerFlag = st_reg.secFlag;
  assign rdData             = st_reg.rdData;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_boundary;
    tick && !violInc;
  endsequence
  sequence s_refreshed;
    (st_reg.violRun == '0) ##0 oneSecondTimerFlag;
  endsequence

  a_boundary_copy: assert property (s_boundary |=> s_refreshed)
    else $error("running violation count not restarted");
  a_held_latch: assert property (s_boundary |=> st_reg.violHeld == $past(st_reg.violRun))
    else $error("violation count not latched at boundary");
  a_viol_saturate: assert property ((st_reg.violRun == e1pc_pkg::VIOL_MAX) && !tick
                                    |=> st_reg.violRun == e1pc_pkg::VIOL_MAX)
    else $error("violation count wrapped");
  a_viol_in_loss: assert property (violInc && receiveSyncLossStatus && !tick &&
                                   st_reg.violRun != e1pc_pkg::VIOL_MAX
                                   |=> st_reg.violRun == 16'($past(st_reg.violRun) + 16'h0001))
    else $error("violation count stopped during sync loss");
  a_bpv_counted: assert property (mark && !violationTypeSelect && !receiveLineCodeSelect &&
                                  st_reg.haveMark && rxPosMark == st_reg.lastMarkPos |-> violInc)
    else $error("bipolar violation missed");
  a_hdb3_skipped: assert property (mark && !violationTypeSelect && receiveLineCodeSelect &&
                                   st_reg.zeroRun >= 2'd2 |-> !violInc)
    else $error("substitution codeword counted");
  a_cv_polarity: assert property (violationTypeSelect && violInc |-> bpv &&
                                  rxPosMark == st_reg.lastBpvPos)
    else $error("code violation without matching polarity");
  a_crc_frozen: assert property (crcMultiframeSyncLoss && !tick
                                 |=> $stable(st_reg.crcRun) && $stable(st_reg.febeRun))
    else $error("crc or far-end count moved during sync loss");
  a_far_end_block_error_count: assert property (eBitStrobe && !eBitValue && !framingLost && !tick
                                 |=> st_reg.febeRun == 10'($past(st_reg.febeRun) + 10'h001))
    else $error("zero E bit not counted");
  a_fas_frozen: assert property (receiveSyncLossStatus && !tick |=> $stable(st_reg.fasRun))
    else $error("alignment count moved during sync loss");
  a_read_shared: assert property (rdAddr == e1pc_pkg::ADDR_CRC_FAS_HIGH
                                  |=> rdData == {$past(st_reg.fasHeld[11:6]), $past(st_reg.crcHeld[9:8])})
    else $error("shared byte at 02 misplaced");
  a_read_far_end_block_error: assert property (rdAddr == e1pc_pkg::ADDR_FAR_END_BLOCK_ERROR_FAS_LOW
                                |=> rdData == {$past(st_reg.fasHeld[5:0]), $past(st_reg.febeHeld[9:8])})
    else $error("shared byte at 04 misplaced");

  sequence s_quiet_cycle;
    !tick;
  endsequence
  sequence s_flag_seen;
    oneSecondTimerFlag;
  endsequence
  sequence s_flag_gone;
    !oneSecondTimerFlag;
  endsequence

  a_flag_after_tick: assert property (tick |=> s_flag_seen)
    else $error("timer flag missing after boundary");

  a_flag_one_cycle: assert property (s_flag_seen |=> s_flag_gone)
    else $error("timer flag longer than one cycle");

  a_flag_needs_tick: assert property (s_quiet_cycle |=> s_flag_gone)
    else $error("timer flag without boundary");

  // Held values stand between boundaries; the host may read them any time in the interval
  a_held_steady: assert property (!tick |=> $stable(st_reg.violHeld) && $stable(st_reg.crcHeld) &&
                                  $stable(st_reg.febeHeld) && $stable(st_reg.fasHeld))
    else $error("held count changed between boundaries");

  // CRC count copied with boundary event
  a_crc_latch: assert property (tick |=> st_reg.crcHeld == 10'($past(st_reg.crcRun) + 10'($past(crcInc))))
    else $error("crc count not latched at boundary");

  a_far_end_block_error_latch: assert property (tick |=> st_reg.febeHeld == 10'($past(st_reg.febeRun) + 10'($past(febeInc))))
    else $error("far-end count not latched at boundary");

  a_fas_latch: assert property (tick |=> st_reg.fasHeld == 12'($past(st_reg.fasRun) + 12'($past(fasInc))))
    else $error("alignment count not latched at boundary");

  a_run_restart: assert property (tick |=> st_reg.crcRun == 10'($past(crcInc)) &&
                                  st_reg.febeRun == 10'($past(febeInc)) && st_reg.fasRun == 12'($past(fasInc)))
    else $error("running count not restarted");

  a_crc_count: assert property (crcErrorPulse && !framingLost && !tick
                                |=> st_reg.crcRun == 10'($past(st_reg.crcRun) + 10'h001))
    else $error("crc error not counted");

  a_receive_sync_loss_status_frozen: assert property (receiveSyncLossStatus && !tick
                                  |=> $stable(st_reg.crcRun) && $stable(st_reg.febeRun))
    else $error("crc or far-end count moved during frame loss");

  a_ebit_one_ignored: assert property (eBitStrobe && eBitValue |-> !febeInc)
    else $error("E bit of one counted");

  a_fas_count: assert property (fasErrorPulse && !receiveSyncLossStatus && !tick
                                |=> st_reg.fasRun == 12'($past(st_reg.fasRun) + 12'h001))
    else $error("alignment error not counted");

  // Multiframe loss alone keeps alignment counting
  a_fas_ignores_crc: assert property (fasErrorPulse && crcMultiframeSyncLoss && !receiveSyncLossStatus |-> fasInc)
    else $error("alignment error dropped on multiframe loss");

  a_read_viol_high: assert property (rdAddr == e1pc_pkg::ADDR_VIOL_HIGH
                                     |=> rdData == $past(st_reg.violHeld[15:8]))
    else $error("violation high byte misplaced");

  a_read_viol_low: assert property (rdAddr == e1pc_pkg::ADDR_VIOL_LOW
                                    |=> rdData == $past(st_reg.violHeld[7:0]))
    else $error("violation low byte misplaced");

  a_read_crc_low: assert property (rdAddr == e1pc_pkg::ADDR_CRC_LOW
                                   |=> rdData == $past(st_reg.crcHeld[7:0]))
    else $error("crc low byte misplaced");

  a_read_far_end_block_error_low: assert property (rdAddr == e1pc_pkg::ADDR_FAR_END_BLOCK_ERROR_LOW
                                    |=> rdData == $past(st_reg.febeHeld[7:0]))
    else $error("far-end low byte misplaced");

  a_read_unmapped: assert property (rdAddr > e1pc_pkg::ADDR_FAR_END_BLOCK_ERROR_LOW |=> rdData == e1pc_pkg::READ_UNMAPPED)
    else $error("unmapped address read nonzero");

  a_cv_needs_pair: assert property (violationTypeSelect && bpv && st_reg.haveBpv &&
                                    rxPosMark == st_reg.lastBpvPos |-> violInc)
    else $error("code violation missed");

  a_count_needs_bpv: assert property (violInc |-> bpv)
    else $error("violation counted without violation");

  a_bpv_needs_mark: assert property (bpv |-> mark)
    else $error("violation without mark");

  // A mark restarts the zero run, so substitution detection looks at this gap only
  a_zero_restart: assert property (mark |=> st_reg.zeroRun == 2'd0)
    else $error("zero run not restarted by mark");

  // Violation count advances below full scale
  a_viol_count: assert property (violInc && !tick && st_reg.violRun != e1pc_pkg::VIOL_MAX
                                 |=> st_reg.violRun == 16'($past(st_reg.violRun) + 16'h0001))
    else $error("violation not counted");
endmodule
`default_nettype wire

/* verif/e1pc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host on the read port: one address every two cycles, data taken one cycle later
module e1pc_host_model (
  input  wire logic                        clock,
  input  wire logic [e1pc_pkg::DATA_W-1:0] rdData,
  output var  logic [e1pc_pkg::ADDR_W-1:0] rdAddr
);
  initial rdAddr = 8'h00;
  // read before boundary
  // Callers read right after the flag, so the held values cannot move under them
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clock);
    rdAddr = addr;
    @(negedge clock);
    data = rdData;
  endtask
endmodule
`default_nettype wire

/* verif/e1_error_performance_counters_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module e1_error_performance_counters_tb;
  localparam int LONG_T   = 1000;
  localparam int SHORT_T  = 150;
  localparam int SAT_LONG = 80000;
  typedef struct packed {
    logic        sel, vts, hdb, sl, cl, pol, ev;
    logic [3:0]  k, z;
    logic [9:0]  n;
    logic [15:0] viol;
    logic [9:0]  crc, far_end_block_error;
    logic [11:0] frame_alignment_word;
  } e1pc_row_t;
  logic       clock, rst, intervalSelect, violationTypeSelect, receiveLineCodeSelect, rxBitValid;
  logic       rxPosMark, rxNegMark, crcErrorPulse, eBitStrobe, eBitValue, fasErrorPulse;
  logic       receiveSyncLossStatus, crcMultiframeSyncLoss, oneSecondTimerFlag, satFlag;
  logic [7:0] rdAddr, rdData, rdDataSat, d;
  e1pc_row_t  rows [8];
  int         cyc = 0;
  int         lastFlag, miscompares, checksDone, gap, t;

  e1pc_error_counters #(.LONG_CYCLES(LONG_T), .SHORT_CYCLES(SHORT_T)) e1pc_error_counters_inst (
    .clock, .rst, .intervalSelect, .violationTypeSelect, .receiveLineCodeSelect, .rxBitValid, .rxPosMark,
    .rxNegMark, .crcErrorPulse, .eBitStrobe, .eBitValue, .fasErrorPulse, .receiveSyncLossStatus,
    .crcMultiframeSyncLoss, .rdAddr, .rdData, .oneSecondTimerFlag);
  // Second copy with a long interval so one interval can overfill the violation count
  e1pc_error_counters #(.LONG_CYCLES(SAT_LONG), .SHORT_CYCLES(SHORT_T)) e1pc_error_counters_sat_inst (
    .clock, .rst, .intervalSelect(1'h0), .violationTypeSelect, .receiveLineCodeSelect, .rxBitValid,
    .rxPosMark, .rxNegMark, .crcErrorPulse, .eBitStrobe, .eBitValue, .fasErrorPulse, .receiveSyncLossStatus,
    .crcMultiframeSyncLoss, .rdAddr, .rdData(rdDataSat), .oneSecondTimerFlag(satFlag));
  e1pc_host_model e1pc_host_model_inst (.clock, .rdData, .rdAddr);

  // Clock at 40 MHz and a free cycle count for interval lengths
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_gap(input int got, input int exp, input string what);
    checksDone++;
    if (got != exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d checks, %0d mismatches", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Bounded wait for the interval pulse; gap is cycles since the previous one
  task automatic wait_flag(output int g);
    int n;
    n = 0;
    @(negedge clock);
    while (oneSecondTimerFlag !== 1'b1 && n < 2 * LONG_T) begin
      @(negedge clock);
      n++;
    end
    if (n >= 2 * LONG_T) cmp_gap(0, 1, "flag missing");
    g = cyc - lastFlag;
    lastFlag = cyc;
  endtask

  // Lead mark opposite to pol, then k marks of pol each after z spaces, and n events
  task automatic run_row(input e1pc_row_t r, input int idx);
    int s;
    int g;
    logic m;
    logic q;
    logic [7:0] b;
    logic [7:0] e [6];
    s = 1 + r.k * (r.z + 1);
    @(negedge clock);
    {intervalSelect, violationTypeSelect, receiveLineCodeSelect, receiveSyncLossStatus, crcMultiframeSyncLoss} =
      {r.sel, r.vts, r.hdb, r.sl, r.cl};
    for (int i = 0; i < s || i < r.n; i++) begin
      m = (i == 0) || (i < s && (i - 1) % (r.z + 1) == r.z);
      q = (i == 0) ? ~r.pol : r.pol;
      {rxBitValid, rxPosMark, rxNegMark, eBitValue} = {i < s, m & q, m & ~q, r.ev};
      {crcErrorPulse, eBitStrobe, fasErrorPulse} = {3{i < r.n}};
      @(negedge clock);
    end
    {rxBitValid, rxPosMark, rxNegMark, crcErrorPulse, eBitStrobe, fasErrorPulse} = 6'h00;
    wait_flag(g);
    if (idx > 0) cmp_gap(g, r.sel ? SHORT_T : LONG_T, "interval length");
    e = '{r.viol[15:8], r.viol[7:0], {r.frame_alignment_word[11:6], r.crc[9:8]}, r.crc[7:0], {r.frame_alignment_word[5:0], r.far_end_block_error[9:8]}, r.far_end_block_error[7:0]};
    for (int a = 0; a < 6; a++) begin
      e1pc_host_model_inst.read_reg(8'(a), b);
      cmp_byte(b, e[a], "row byte");
    end
    $display("Row %0d test done", idx);
  endtask

  initial begin
    // Flags are sel vts hdb sl cl pol ev, then k, z, n and the expected counts
    // expected counts
    rows[0] = {7'h42, 4'h5, 4'h0, 10'h003, 16'h0004, 10'h003, 10'h003, 12'h003};
    rows[1] = {7'h53, 4'h4, 4'h2, 10'h005, 16'h0000, 10'h005, 10'h000, 12'h005};
    rows[2] = {7'h42, 4'h4, 4'h2, 10'h002, 16'h0003, 10'h002, 10'h002, 12'h002};
    rows[3] = {7'h4A, 4'h3, 4'h0, 10'h004, 16'h0002, 10'h000, 10'h000, 12'h000};
    rows[4] = {7'h46, 4'h3, 4'h0, 10'h004, 16'h0002, 10'h000, 10'h000, 12'h004};
    rows[5] = {7'h60, 4'h3, 4'h0, 10'h000, 16'h0002, 10'h000, 10'h000, 12'h000};
    rows[6] = {7'h62, 4'h4, 4'h0, 10'h000, 16'h0003, 10'h000, 10'h000, 12'h000};
    rows[7] = {7'h02, 4'h1, 4'h0, 10'h2BC, 16'h0000, 10'h2BC, 10'h2BC, 12'h2BC};
    {rst, intervalSelect, violationTypeSelect, receiveLineCodeSelect, rxBitValid, rxPosMark, rxNegMark} = 7'h60;
    {crcErrorPulse, eBitStrobe, eBitValue, fasErrorPulse, receiveSyncLossStatus, crcMultiframeSyncLoss} = 6'h00;
    miscompares = 0;
    checksDone = 0;
    lastFlag = 0;
    repeat (10) @(negedge clock);
    cmp_byte(rdData, 8'h00, "data in reset");
    cmp_byte({7'h00, oneSecondTimerFlag}, 8'h00, "flag in reset");
    rst = 1'h0;
    // One positive mark first, so the first row starts from a known polarity history
    @(negedge clock);
    {rxBitValid, rxPosMark} = 2'h3;
    @(negedge clock);
    {rxBitValid, rxPosMark} = 2'h0;
    wait_flag(gap);
    $display("Reset test done");
    for (int r = 0; r < 8; r++) run_row(rows[r], r);
    e1pc_host_model_inst.read_reg(8'h06, d);
    cmp_byte(d, 8'h00, "unmapped 06");
    e1pc_host_model_inst.read_reg(8'hFF, d);
    cmp_byte(d, 8'h00, "unmapped FF");
    $display("Unmapped test done");
    {rxBitValid, rxPosMark} = 2'h3;
    repeat (66000) @(negedge clock);
    {rxBitValid, rxPosMark} = 2'h0;
    t = 0;
    while (satFlag !== 1'b1 && t < 20000) begin
      @(negedge clock);
      t++;
    end
    if (t >= 20000) cmp_gap(0, 1, "saturation flag missing");
    e1pc_host_model_inst.read_reg(8'h00, d);
    cmp_byte(rdDataSat, 8'hFF, "saturated high");
    e1pc_host_model_inst.read_reg(8'h01, d);
    cmp_byte(rdDataSat, 8'hFF, "saturated low");
    $display("Saturation test done");
    // Reset in mid-run: timer restarts and held counts read zero
    @(negedge clock);
    rst = 1'h1;
    @(negedge clock);
    cmp_byte(rdData, 8'h00, "data in second reset");
    rst = 1'h0;
    lastFlag = cyc;
    wait_flag(gap);
    cmp_gap(gap, LONG_T + 1, "first interval after reset");
    for (int a = 0; a < 6; a++) begin
      e1pc_host_model_inst.read_reg(8'(a), d);
      cmp_byte(d, 8'h00, "empty interval");
    end
    $display("Second reset test done");
    tally_and_finish();
  end

  // Watchdog: the run needs about 81000 cycles
  initial begin
    #(95000 * 25);
    cmp_gap(0, 1, "watchdog expired");
    tally_and_finish();
  end
endmodule
`default_nettype wire
